// *** hdl/uis_pkg.sv ***
package uis_pkg;
	localparam int unsigned CLK_PERIOD_NS    = 100;
	localparam int unsigned TICK_NS          = 100_000;
	localparam int unsigned TICK_CYC         = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned PLL_SETTLE_NS    = 1_000_000;
	localparam int unsigned PLL_SETTLE_TICKS = PLL_SETTLE_NS / TICK_NS;
	localparam int unsigned WAKE_LIMIT_NS    = 20_000_000;
	localparam int unsigned WAKE_LIMIT_TICKS = WAKE_LIMIT_NS / TICK_NS;
	localparam int unsigned FIFO_DEPTH       = 64;

	localparam logic [7:0] ADDR_USB_GLOBAL_CTRL = 8'h00;
	localparam logic [7:0] ADDR_USB_EVENT       = 8'h01;
	localparam logic [7:0] ADDR_ENDPOINT_SELECT = 8'h02;
	localparam logic [7:0] ADDR_ENDPOINT_STATUS = 8'h03;
	localparam logic [7:0] ADDR_RX_BYTE_COUNT   = 8'h04;
	localparam logic [7:0] ADDR_ENDPOINT_FIFO   = 8'h05;
	localparam logic [7:0] ADDR_ENDPOINT_RESET  = 8'h06;
	localparam logic [7:0] ADDR_FRAME_LOW       = 8'h07;
	localparam logic [7:0] ADDR_FRAME_HIGH      = 8'h08;
	localparam logic [7:0] ADDR_PLL_CTRL        = 8'h09;

	localparam logic [7:0] CTRL_ENABLE        = 8'h80;
	localparam logic [7:0] CTRL_CLOCK_GATE    = 8'h40;
	localparam logic [7:0] CTRL_SEND_WAKE     = 8'h20;
	localparam logic [7:0] CTRL_RESUME_ACTIVE = 8'h08;
	localparam logic [7:0] CTRL_WAKE_ALLOW    = 8'h04;
	localparam logic [7:0] CTRL_RESET         = 8'h80;
	localparam logic [7:0] EVT_SUSPEND        = 8'h01;
	localparam logic [7:0] STAT_TX_DONE       = 8'h01;
	localparam logic [7:0] STAT_BANK0_RX      = 8'h02;
	localparam logic [7:0] STAT_BANK1_RX      = 8'h40;
	localparam logic [7:0] STAT_TX_READY      = 8'h10;
	localparam logic [7:0] STAT_STALL_REQ     = 8'h20;
	localparam logic [7:0] PLL_ON             = 8'h02;
	localparam logic       PLL_ON_RESET       = 1'b1;

	typedef enum logic [3:0] {
		CMD_RX_BANK     = 4'h0,
		CMD_TX_PACKET   = 4'h1,
		CMD_STALL       = 4'h2,
		CMD_UNSTALL     = 4'h3,
		CMD_EP_RESET    = 4'h4,
		CMD_SUSPEND     = 4'h5,
		CMD_RESUME      = 4'h6,
		CMD_REMOTE_WAKE = 4'h7,
		CMD_WAKE_ALLOW  = 4'h8,
		CMD_FRAME       = 4'h9
	} uis_cmd_e;
endpackage : uis_pkg

// *** hdl/uis_tick.sv ***
`timescale 1ns/100ps
`default_nettype none
module uis_tick #(
	parameter int unsigned DIV = 1000
) (
	input  wire logic clk,
	input  wire logic rst_b,
	output logic      tick
);
	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          tick_q;
	logic          tick_d;

	always_comb begin
		if (cnt_q == CW'(DIV - 1)) begin
			cnt_d  = '0;
			tick_d = 1'b1;
		end else begin
			cnt_d  = cnt_q + 1'b1;
			tick_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule : uis_tick
`default_nettype wire

// *** hdl/uis_regio.sv ***
`timescale 1ns/100ps
`default_nettype none
module uis_regio #(
	parameter int unsigned AW = 8,
	parameter int unsigned DW = 8
) (
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic          op_valid,
	input  wire logic          op_write,
	input  wire logic [AW-1:0] op_addr,
	input  wire logic [DW-1:0] op_wdata,
	output logic               op_done,
	output logic [DW-1:0]      op_rdata,
	output logic [AW-1:0]      dev_addr,
	output logic [DW-1:0]      dev_wdata,
	output logic               dev_wr_en,
	output logic               dev_rd_en,
	input  wire logic [DW-1:0] dev_rdata
);
	logic [AW-1:0] addr_q, addr_d;
	logic [DW-1:0] wdata_q, wdata_d;
	logic [DW-1:0] rdata_q, rdata_d;
	logic          wr_q, wr_d;
	logic          rd_q, rd_d;
	logic          done_q, done_d;

	// One strobe cycle, then a done pulse; no relaunch in the done cycle
	always_comb begin
		addr_d  = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		wr_d    = 1'b0;
		rd_d    = 1'b0;
		done_d  = 1'b0;
		if (wr_q || rd_q) begin
			done_d = 1'b1;
			if (rd_q) begin
				rdata_d = dev_rdata;
			end
		end else if (op_valid && !done_q) begin
			addr_d  = op_addr;
			wdata_d = op_wdata;
			wr_d    = op_write;
			rd_d    = !op_write;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			addr_q  <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			wr_q    <= 1'b0;
			rd_q    <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			addr_q  <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			wr_q    <= wr_d;
			rd_q    <= rd_d;
			done_q  <= done_d;
		end
	end

	assign op_done   = done_q;
	assign op_rdata  = rdata_q;
	assign dev_addr  = addr_q;
	assign dev_wdata = wdata_q;
	assign dev_wr_en = wr_q;
	assign dev_rd_en = rd_q;
endmodule : uis_regio
`default_nettype wire

// *** hdl/uis_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
module uis_ctrl #(
	parameter int unsigned TICK_DIV   = uis_pkg::TICK_CYC,
	parameter int unsigned FIFO_BYTES = uis_pkg::FIFO_DEPTH
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              cmd_valid,
	input  wire uis_pkg::uis_cmd_e cmd_code,
	input  wire logic [2:0]        cmd_ep,
	input  wire logic [7:0]        cmd_len,
	input  wire logic              cmd_arg,
	output logic                   cmd_ready,
	output logic                   cmd_done,
	output logic                   cmd_error,
	input  wire logic [7:0]        tx_data,
	output logic                   tx_take,
	output logic [7:0]             rx_data,
	output logic                   rx_valid,
	output logic [10:0]            frame_number,
	output logic [7:0]             dev_addr,
	output logic [7:0]             dev_wdata,
	output logic                   dev_wr_en,
	output logic                   dev_rd_en,
	input  wire logic [7:0]        dev_rdata
);
	import uis_pkg::*;

	typedef enum logic [4:0] {
		ST_IDLE     = 5'h00, ST_SEL     = 5'h01, ST_RX_CNT  = 5'h02,
		ST_RX_BYTE  = 5'h03, ST_RX_STAT = 5'h04, ST_RX_CLR  = 5'h05,
		ST_TX_STAT  = 5'h06, ST_TX_CLR  = 5'h07, ST_TX_BYTE = 5'h08,
		ST_TX_NEXT  = 5'h09, ST_TX_RDY  = 5'h0a, ST_ST_CLR  = 5'h0b,
		ST_ST_SET   = 5'h0c, ST_EP_RST  = 5'h0d, ST_EP_REL  = 5'h0e,
		ST_EV_RD    = 5'h0f, ST_EV_CLR  = 5'h10, ST_CTRL_WR = 5'h11,
		ST_PLL_WR   = 5'h12, ST_PLL_WT  = 5'h13, ST_POLL    = 5'h14,
		ST_POLL_GAP = 5'h15, ST_FR_LO   = 5'h16, ST_FR_HI   = 5'h17,
		ST_FIN      = 5'h18
	} uis_state_e;

	localparam logic [7:0] FIFO_CAP = 8'(FIFO_BYTES);
	localparam logic [7:0] SETTLE   = 8'(PLL_SETTLE_TICKS);
	localparam logic [7:0] WAKE_LIM = 8'(WAKE_LIMIT_TICKS);

	uis_state_e  state_q, state_d;
	uis_cmd_e    cmd_q, cmd_d;
	logic [2:0]  ep_q, ep_d;
	logic [7:0]  len_q, len_d;
	logic [7:0]  idx_q, idx_d;
	logic [7:0]  stat_q, stat_d;
	logic [7:0]  ctrl_q, ctrl_d;
	logic [7:0]  ctrl_nx;
	logic [7:0]  tmr_q, tmr_d;
	logic [7:0]  lo_q, lo_d;
	logic [7:0]  rxd_q, rxd_d;
	logic [10:0] frame_q, frame_d;
	logic        arg_q, arg_d;
	logic        pll_q, pll_d;
	logic        seen_q, seen_d;
	logic        sent_q, sent_d;
	logic        err_q, err_d;
	logic        done_q, done_d;
	logic        take_q, take_d;
	logic        rxv_q, rxv_d;
	logic        ready_q, ready_d;
	logic        op_valid;
	logic        op_write;
	logic [7:0]  op_addr;
	logic [7:0]  op_wdata;
	logic        op_done;
	logic [7:0]  op_rdata;
	logic        tick;

	uis_regio #(.AW(8), .DW(8)) u_regio (
		.clk       (clk),
		.rst_b     (rst_b),
		.op_valid  (op_valid),
		.op_write  (op_write),
		.op_addr   (op_addr),
		.op_wdata  (op_wdata),
		.op_done   (op_done),
		.op_rdata  (op_rdata),
		.dev_addr  (dev_addr),
		.dev_wdata (dev_wdata),
		.dev_wr_en (dev_wr_en),
		.dev_rd_en (dev_rd_en),
		.dev_rdata (dev_rdata)
	);

	uis_tick #(.DIV(TICK_DIV)) u_tick (
		.clk   (clk),
		.rst_b (rst_b),
		.tick  (tick)
	);

	// Global control image for the write in progress
	always_comb begin
		case (cmd_q)
			CMD_SUSPEND:     ctrl_nx = ctrl_q | CTRL_CLOCK_GATE;
			CMD_RESUME:      ctrl_nx = ctrl_q & ~CTRL_CLOCK_GATE;
			CMD_REMOTE_WAKE: ctrl_nx = sent_q ? (ctrl_q & ~CTRL_SEND_WAKE)
			                                  : (ctrl_q | CTRL_SEND_WAKE);
			CMD_WAKE_ALLOW:  ctrl_nx = arg_q ? (ctrl_q | CTRL_WAKE_ALLOW)
			                                 : (ctrl_q & ~CTRL_WAKE_ALLOW);
			default:         ctrl_nx = ctrl_q;
		endcase
	end

	always_comb begin
		state_d  = state_q;
		cmd_d    = cmd_q;
		ep_d     = ep_q;
		len_d    = len_q;
		idx_d    = idx_q;
		stat_d   = stat_q;
		ctrl_d   = ctrl_q;
		tmr_d    = tmr_q;
		lo_d     = lo_q;
		rxd_d    = rxd_q;
		frame_d  = frame_q;
		arg_d    = arg_q;
		pll_d    = pll_q;
		seen_d   = seen_q;
		sent_d   = sent_q;
		err_d    = err_q;
		done_d   = 1'b0;
		take_d   = 1'b0;
		rxv_d    = 1'b0;
		op_valid = 1'b0;
		op_write = 1'b0;
		op_addr  = ADDR_USB_GLOBAL_CTRL;
		op_wdata = 8'h00;
		case (state_q)
			ST_IDLE: if (cmd_valid) begin
				cmd_d  = cmd_code;
				ep_d   = cmd_ep;
				len_d  = cmd_len;
				arg_d  = cmd_arg;
				idx_d  = 8'h00;
				tmr_d  = 8'h00;
				seen_d = 1'b0;
				sent_d = 1'b0;
				err_d  = 1'b0;
				case (cmd_code)
					CMD_TX_PACKET: if (cmd_len > FIFO_CAP) begin
						err_d   = 1'b1;
						state_d = ST_FIN;
					end else begin
						state_d = ST_SEL;
					end
					CMD_RX_BANK, CMD_STALL, CMD_UNSTALL: state_d = ST_SEL;
					CMD_EP_RESET:                        state_d = ST_EP_RST;
					CMD_SUSPEND, CMD_REMOTE_WAKE:        state_d = ST_EV_RD;
					CMD_RESUME:                          state_d = ST_PLL_WR;
					CMD_WAKE_ALLOW:                      state_d = ST_CTRL_WR;
					CMD_FRAME:                           state_d = ST_FR_LO;
					default: begin
						err_d   = 1'b1;
						state_d = ST_FIN;
					end
				endcase
			end
			ST_SEL: begin
				op_valid = 1'b1;
				op_write = 1'b1;
				op_addr  = ADDR_ENDPOINT_SELECT;
				op_wdata = {5'h00, ep_q};
				if (op_done) begin
					case (cmd_q)
						CMD_RX_BANK:   state_d = ST_RX_CNT;
						CMD_TX_PACKET: state_d = ST_TX_STAT;
						default:       state_d = ST_ST_CLR;
					endcase
				end
			end
			ST_RX_CNT: begin
				op_valid = 1'b1;
				op_addr  = ADDR_RX_BYTE_COUNT;
				if (op_done) begin
					len_d   = (op_rdata > FIFO_CAP) ? FIFO_CAP : op_rdata;
					state_d = (op_rdata == 8'h00) ? ST_RX_STAT : ST_RX_BYTE;
				end
			end
			ST_RX_BYTE: begin
				op_valid = 1'b1;
				op_addr  = ADDR_ENDPOINT_FIFO;
				if (op_done) begin
					rxd_d = op_rdata;
					rxv_d = 1'b1;
					idx_d = idx_q + 8'h01;
					if (idx_q + 8'h01 == len_q) begin
						state_d = ST_RX_STAT;
					end
				end
			end
			ST_RX_STAT: begin
				op_valid = 1'b1;
				op_addr  = ADDR_ENDPOINT_STATUS;
				if (op_done) begin
					stat_d = op_rdata;
					if ((op_rdata & (STAT_BANK0_RX | STAT_BANK1_RX)) != 8'h00) begin
						state_d = ST_RX_CLR;
					end else begin
						err_d   = 1'b1;
						state_d = ST_FIN;
					end
				end
			end
			ST_RX_CLR: begin
				op_valid = 1'b1;
				op_write = 1'b1;
				op_addr  = ADDR_ENDPOINT_STATUS;
				op_wdata = ((stat_q & STAT_BANK0_RX) != 8'h00)
				         ? (stat_q & ~STAT_BANK0_RX) : (stat_q & ~STAT_BANK1_RX);
				if (op_done) begin
					state_d = ST_FIN;
				end
			end
			ST_TX_STAT: begin
				op_valid = 1'b1;
				op_addr  = ADDR_ENDPOINT_STATUS;
				if (op_done) begin
					stat_d = op_rdata;
					if ((op_rdata & STAT_TX_DONE) != 8'h00) begin
						state_d = ST_TX_CLR;
					end else begin
						state_d = (len_q == 8'h00) ? ST_TX_RDY : ST_TX_BYTE;
					end
				end
			end
			ST_TX_CLR: begin
				op_valid = 1'b1;
				op_write = 1'b1;
				op_addr  = ADDR_ENDPOINT_STATUS;
				op_wdata = stat_q & ~STAT_TX_DONE;
				if (op_done) begin
					stat_d  = stat_q & ~STAT_TX_DONE;
					state_d = (len_q == 8'h00) ? ST_TX_RDY : ST_TX_BYTE;
				end
			end
			ST_TX_BYTE: begin
				op_valid = 1'b1;
				op_write = 1'b1;
				op_addr  = ADDR_ENDPOINT_FIFO;
				op_wdata = tx_data;
				if (op_done) begin
					take_d  = 1'b1;
					idx_d   = idx_q + 8'h01;
					state_d = (idx_q + 8'h01 == len_q) ? ST_TX_RDY : ST_TX_NEXT;
				end
			end
			ST_TX_NEXT: state_d = ST_TX_BYTE;
			ST_TX_RDY: begin
				op_valid = 1'b1;
				op_write = 1'b1;
				op_addr  = ADDR_ENDPOINT_STATUS;
				op_wdata = stat_q | STAT_TX_READY;
				if (op_done) begin
					state_d = ST_FIN;
				end
			end
			ST_ST_CLR: begin
				op_valid = 1'b1;
				op_write = 1'b1;
				op_addr  = ADDR_ENDPOINT_STATUS;
				if (op_done) begin
					state_d = (cmd_q == CMD_STALL) ? ST_ST_SET : ST_FIN;
				end
			end
			ST_ST_SET: begin
				op_valid = 1'b1;
				op_write = 1'b1;
				op_addr  = ADDR_ENDPOINT_STATUS;
				op_wdata = STAT_STALL_REQ;
				if (op_done) begin
					state_d = ST_FIN;
				end
			end
			ST_EP_RST, ST_EP_REL: begin
				op_valid = 1'b1;
				op_write = 1'b1;
				op_addr  = ADDR_ENDPOINT_RESET;
				op_wdata = (state_q == ST_EP_RST) ? (8'h01 << ep_q) : 8'h00;
				if (op_done) begin
					state_d = (state_q == ST_EP_RST) ? ST_EP_REL : ST_FIN;
				end
			end
			ST_EV_RD: begin
				op_valid = 1'b1;
				op_addr  = ADDR_USB_EVENT;
				if (op_done) begin
					stat_d  = op_rdata;
					state_d = ST_EV_CLR;
				end
			end
			ST_EV_CLR: begin
				op_valid = 1'b1;
				op_write = 1'b1;
				op_addr  = ADDR_USB_EVENT;
				op_wdata = stat_q & ~EVT_SUSPEND;
				if (op_done) begin
					state_d = (cmd_q == CMD_RESUME) ? ST_FIN : ST_CTRL_WR;
				end
			end
			ST_CTRL_WR: begin
				op_valid = 1'b1;
				op_write = 1'b1;
				op_wdata = ctrl_nx;
				if (op_done) begin
					ctrl_d = ctrl_nx;
					case (cmd_q)
						CMD_SUSPEND: state_d = ST_PLL_WR;
						CMD_RESUME:  state_d = ST_EV_RD;
						CMD_REMOTE_WAKE: if (sent_q) begin
							state_d = ST_FIN;
						end else begin
							sent_d  = 1'b1;
							tmr_d   = 8'h00;
							state_d = ST_POLL;
						end
						default: state_d = ST_FIN;
					endcase
				end
			end
			ST_PLL_WR: begin
				op_valid = 1'b1;
				op_write = 1'b1;
				op_addr  = ADDR_PLL_CTRL;
				op_wdata = (cmd_q == CMD_RESUME) ? PLL_ON : 8'h00;
				if (op_done) begin
					pll_d   = (cmd_q == CMD_RESUME);
					tmr_d   = 8'h00;
					state_d = (cmd_q == CMD_RESUME) ? ST_PLL_WT : ST_FIN;
				end
			end
			ST_PLL_WT: if (tmr_q == SETTLE) begin
				state_d = ST_CTRL_WR;
			end else if (tick) begin
				tmr_d = tmr_q + 8'h01;
			end
			ST_POLL: begin
				op_valid = 1'b1;
				if (op_done) begin
					if ((op_rdata & CTRL_RESUME_ACTIVE) != 8'h00) begin
						seen_d  = 1'b1;
						state_d = ST_POLL_GAP;
					end else begin
						state_d = seen_q ? ST_CTRL_WR : ST_POLL_GAP;
					end
				end
			end
			ST_POLL_GAP: if (tmr_q == WAKE_LIM) begin
				err_d   = 1'b1;
				state_d = ST_CTRL_WR;
			end else if (tick) begin
				tmr_d   = tmr_q + 8'h01;
				state_d = ST_POLL;
			end
			ST_FR_LO, ST_FR_HI: begin
				op_valid = 1'b1;
				op_addr  = (state_q == ST_FR_LO) ? ADDR_FRAME_LOW : ADDR_FRAME_HIGH;
				if (op_done) begin
					if (state_q == ST_FR_LO) begin
						lo_d    = op_rdata;
						state_d = ST_FR_HI;
					end else begin
						frame_d = {op_rdata[2:0], lo_q};
						state_d = ST_FIN;
					end
				end
			end
			ST_FIN: begin
				done_d  = 1'b1;
				state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
		ready_d = (state_d == ST_IDLE);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			cmd_q   <= CMD_RX_BANK;
			ep_q    <= 3'h0;
			len_q   <= 8'h00;
			idx_q   <= 8'h00;
			stat_q  <= 8'h00;
			ctrl_q  <= CTRL_RESET;
			tmr_q   <= 8'h00;
			lo_q    <= 8'h00;
			rxd_q   <= 8'h00;
			frame_q <= 11'h000;
			arg_q   <= 1'b0;
			pll_q   <= PLL_ON_RESET;
			seen_q  <= 1'b0;
			sent_q  <= 1'b0;
			err_q   <= 1'b0;
			done_q  <= 1'b0;
			take_q  <= 1'b0;
			rxv_q   <= 1'b0;
			ready_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cmd_q   <= cmd_d;
			ep_q    <= ep_d;
			len_q   <= len_d;
			idx_q   <= idx_d;
			stat_q  <= stat_d;
			ctrl_q  <= ctrl_d;
			tmr_q   <= tmr_d;
			lo_q    <= lo_d;
			rxd_q   <= rxd_d;
			frame_q <= frame_d;
			arg_q   <= arg_d;
			pll_q   <= pll_d;
			seen_q  <= seen_d;
			sent_q  <= sent_d;
			err_q   <= err_d;
			done_q  <= done_d;
			take_q  <= take_d;
			rxv_q   <= rxv_d;
			ready_q <= ready_d;
		end
	end

	assign cmd_ready    = ready_q;
	assign cmd_done     = done_q;
	assign cmd_error    = err_q;
	assign tx_take      = take_q;
	assign rx_data      = rxd_q;
	assign rx_valid     = rxv_q;
	assign frame_number = frame_q;

	// Checks on the device-side write stream
	logic [7:0] last_stat_q;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			last_stat_q <= 8'h00;
		end else if (dev_wr_en && dev_addr == ADDR_ENDPOINT_STATUS) begin
			last_stat_q <= dev_wdata;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_evt_clear;
		dev_wr_en && dev_addr == ADDR_USB_EVENT
		&& (dev_wdata & EVT_SUSPEND) == 8'h00;
	endsequence
	sequence s_gate_set;
		dev_wr_en && dev_addr == ADDR_USB_GLOBAL_CTRL
		&& (dev_wdata & CTRL_CLOCK_GATE) != 8'h00;
	endsequence
	sequence s_stat_zero;
		dev_wr_en && dev_addr == ADDR_ENDPOINT_STATUS && dev_wdata == 8'h00;
	endsequence

	a_rx_read_all: assert property (
		(dev_wr_en && state_q == ST_RX_CLR) |-> idx_q == len_q)
		else $error("bank released before all bytes read");
	a_tx_fifo_cap: assert property (
		(dev_wr_en && dev_addr == ADDR_ENDPOINT_FIFO) |-> idx_q < FIFO_CAP)
		else $error("endpoint fifo overfilled");
	a_tx_done_first: assert property (
		(dev_wr_en && dev_addr == ADDR_ENDPOINT_FIFO)
		|-> (stat_q & STAT_TX_DONE) == 8'h00)
		else $error("fifo refilled while done flag set");
	a_stall_after_clr: assert property (
		(dev_wr_en && dev_addr == ADDR_ENDPOINT_STATUS
		 && dev_wdata == STAT_STALL_REQ) |-> $past(last_stat_q, 1) == 8'h00)
		else $error("stall requested without clearing flags");
	a_stall_release: assert property (
		(state_q == ST_IDLE && cmd_valid && cmd_code == CMD_UNSTALL)
		|-> ##[1:12] s_stat_zero)
		else $error("stall request not withdrawn");
	a_ep_reset_pulse: assert property (
		(dev_wr_en && dev_addr == ADDR_ENDPOINT_RESET && dev_wdata != 8'h00)
		|-> ##3 (dev_wr_en && dev_addr == ADDR_ENDPOINT_RESET
		         && dev_wdata == 8'h00))
		else $error("endpoint reset not released");
	a_suspend_gate: assert property (
		(cmd_q == CMD_SUSPEND) ##0 s_evt_clear |-> ##[2:4] s_gate_set)
		else $error("clock not gated after suspend clear");
	a_gate_before_pll: assert property (
		(dev_wr_en && dev_addr == ADDR_PLL_CTRL && dev_wdata == 8'h00)
		|-> (ctrl_q & CTRL_CLOCK_GATE) != 8'h00)
		else $error("pll stopped before clock gated");
	a_resume_order: assert property (
		(cmd_q == CMD_RESUME) ##0 s_evt_clear
		|-> pll_q && (ctrl_q & CTRL_CLOCK_GATE) == 8'h00)
		else $error("suspend cleared before clock restart");
	a_allow_follows: assert property (
		(dev_wr_en && dev_addr == ADDR_USB_GLOBAL_CTRL
		 && cmd_q == CMD_WAKE_ALLOW)
		|-> ((dev_wdata & CTRL_WAKE_ALLOW) != 8'h00) == arg_q)
		else $error("wake permission differs from order");
	a_wake_after_clr: assert property (
		(cmd_q == CMD_REMOTE_WAKE) ##0 s_evt_clear |-> ##[2:4]
		(dev_wr_en && (dev_wdata & CTRL_SEND_WAKE) != 8'h00))
		else $error("wake not sent after suspend clear");
endmodule : uis_ctrl
`default_nettype wire

// *** verification/uis_dev_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module uis_dev_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] dev_addr,
	input  wire logic [7:0] dev_wdata,
	input  wire logic       dev_wr_en,
	input  wire logic       dev_rd_en,
	output logic [7:0]      dev_rdata
);
	logic [7:0] regs [0:15];
	logic [7:0] ptr, last, fifo_last, fifo_n, rst_seen, in_n;
	logic [1:0] rsm;
	// Idle bus shows the inverse of the last value
	assign dev_rdata = !dev_rd_en ? ~last :
		(dev_addr == 8'h05) ? 8'h30 + ptr : regs[dev_addr[3:0]];
	always @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < 16; i++)
				regs[i] <= 8'h00;
			regs[0] <= 8'h80;
			regs[9] <= 8'h02;
			ptr <= 8'h00;
			in_n <= 8'h00;
			fifo_n <= 8'h00;
			rst_seen <= 8'h00;
			rsm <= 2'd0;
		end else begin
			if (dev_rd_en)
				last <= dev_rdata;
			if (dev_rd_en && dev_addr == 8'h05)
				ptr <= ptr + 8'h01;
			if (dev_rd_en && dev_addr == 8'h00 && rsm != 2'd0) begin
				rsm <= rsm - 2'd1;
				if (rsm == 2'd1)
					regs[0][3] <= 1'b0;
			end
			if (dev_wr_en) begin
				regs[dev_addr[3:0]] <= dev_wdata;
				if (dev_addr == 8'h05) begin
					fifo_n <= fifo_n + 8'h01;
					fifo_last <= dev_wdata;
				end
				if (dev_addr == 8'h03 && dev_wdata[4])
					in_n <= fifo_n;
				if (dev_addr == 8'h06 && dev_wdata != 8'h00)
					rst_seen <= dev_wdata;
				if (dev_addr == 8'h00 && dev_wdata[5] && !regs[0][5]) begin
					regs[0][3] <= 1'b1;
					rsm <= 2'd2;
				end
			end
		end
	end
endmodule : uis_dev_model
`default_nettype wire

// *** verification/usb_device_iso_stall_suspend_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module usb_device_iso_stall_suspend_tb_top;
	import uis_pkg::*;
	logic clk, rst_b, cmd_valid, cmd_arg, cmd_ready, cmd_done, cmd_error;
	logic tx_take, rx_valid, dev_wr_en, dev_rd_en, err;
	logic [2:0] cmd_ep;
	logic [7:0] cmd_len, tx_data, rx_data, dev_addr, dev_wdata, dev_rdata;
	logic [7:0] rx_last;
	logic [10:0] frame_number;
	uis_cmd_e cmd_code;
	int mismatches = 0, n_tests = 0, rx_n = 0;
	uis_ctrl #(.TICK_DIV(4)) u_uis_ctrl (.clk(clk), .rst_b(rst_b),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ep(cmd_ep),
		.cmd_len(cmd_len), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
		.cmd_done(cmd_done), .cmd_error(cmd_error), .tx_data(tx_data),
		.tx_take(tx_take), .rx_data(rx_data), .rx_valid(rx_valid),
		.frame_number(frame_number), .dev_addr(dev_addr),
		.dev_wdata(dev_wdata), .dev_wr_en(dev_wr_en),
		.dev_rd_en(dev_rd_en), .dev_rdata(dev_rdata));
	uis_dev_model u_uis_dev_model (.clk(clk), .rst_b(rst_b),
		.dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr_en(dev_wr_en),
		.dev_rd_en(dev_rd_en), .dev_rdata(dev_rdata));
	always #50 clk = ~clk;
	always @(posedge clk) begin
		#1;
		if (rx_valid === 1'b1) begin
			rx_n++;
			rx_last = rx_data;
		end
		if (tx_take === 1'b1)
			tx_data = tx_data + 8'h01;
	end
	task automatic conclude;
		if (mismatches == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic run(input uis_cmd_e c, input logic [7:0] l,
		input logic a);
		int i;
		while (cmd_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		cmd_code = c;
		cmd_len = l;
		cmd_arg = a;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		for (i = 0; i < 3000 && cmd_done !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk("done", 16'h0001, 16'(cmd_done));
		err = cmd_error;
	endtask : run
	initial begin
		#(100 * 20000);
		mismatches++;
		conclude();
	end
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = CMD_FRAME;
		cmd_ep = 3'd3;
		cmd_len = 8'h00;
		cmd_arg = 1'b0;
		tx_data = 8'h50;
		repeat (8) @(posedge clk);
		#1 rst_b = 1'b1;
		chk("ready", 16'h0001, cmd_ready);
		u_uis_dev_model.regs[7] = 8'hA5;
		u_uis_dev_model.regs[8] = 8'hFE;
		run(CMD_FRAME, 8'h00, 1'b0);
		chk("frame", 16'h06A5, frame_number);
		u_uis_dev_model.regs[4] = 8'd3;
		u_uis_dev_model.regs[3] = 8'h03;
		run(CMD_RX_BANK, 8'h00, 1'b0);
		chk("rx count", 16'd3, rx_n);
		chk("rx byte", 16'h0032, rx_last);
		chk("status", 16'h0001, u_uis_dev_model.regs[3]);
		u_uis_dev_model.regs[4] = 8'd70;
		u_uis_dev_model.regs[3] = 8'h40;
		rx_n = 0;
		run(CMD_RX_BANK, 8'h00, 1'b0);
		chk("rx count", 16'd64, rx_n);
		chk("rx byte", 16'h0072, rx_last);
		chk("status", 16'h0000, u_uis_dev_model.regs[3]);
		u_uis_dev_model.regs[4] = 8'h00;
		u_uis_dev_model.regs[3] = 8'h02;
		rx_n = 0;
		run(CMD_RX_BANK, 8'h00, 1'b0);
		chk("rx count", 16'd0, rx_n);
		chk("status", 16'h0000, u_uis_dev_model.regs[3]);
		run(CMD_RX_BANK, 8'h00, 1'b0);
		chk("no bank", 16'h0001, err);
		u_uis_dev_model.regs[3] = 8'h01;
		run(CMD_TX_PACKET, 8'd2, 1'b0);
		chk("fifo count", 16'd2, u_uis_dev_model.fifo_n);
		chk("fifo byte", 16'h0051, u_uis_dev_model.fifo_last);
		chk("in bytes", 16'd2, u_uis_dev_model.in_n);
		chk("status", 16'h0010, u_uis_dev_model.regs[3]);
		run(CMD_TX_PACKET, 8'd65, 1'b0);
		chk("tx over", 16'h0001, err);
		chk("fifo count", 16'd2, u_uis_dev_model.fifo_n);
		run(CMD_STALL, 8'h00, 1'b0);
		chk("status", 16'h0020, u_uis_dev_model.regs[3]);
		run(CMD_UNSTALL, 8'h00, 1'b0);
		chk("status", 16'h0000, u_uis_dev_model.regs[3]);
		run(CMD_EP_RESET, 8'h00, 1'b0);
		chk("ep reset", 16'h0008, u_uis_dev_model.rst_seen);
		chk("ep reset", 16'h0000, u_uis_dev_model.regs[6]);
		u_uis_dev_model.regs[1] = 8'h01;
		run(CMD_SUSPEND, 8'h00, 1'b0);
		chk("event", 16'h0000, u_uis_dev_model.regs[1]);
		chk("ctrl", 16'h00C0, u_uis_dev_model.regs[0]);
		chk("pll", 16'h0000, u_uis_dev_model.regs[9]);
		u_uis_dev_model.regs[1] = 8'h01;
		run(CMD_RESUME, 8'h00, 1'b0);
		chk("pll", 16'h0002, u_uis_dev_model.regs[9]);
		chk("ctrl", 16'h0080, u_uis_dev_model.regs[0]);
		chk("event", 16'h0000, u_uis_dev_model.regs[1]);
		run(CMD_REMOTE_WAKE, 8'h00, 1'b0);
		chk("wake error", 16'h0000, err);
		chk("ctrl", 16'h0080, u_uis_dev_model.regs[0]);
		run(CMD_WAKE_ALLOW, 8'h00, 1'b1);
		chk("ctrl", 16'h0084, u_uis_dev_model.regs[0]);
		run(CMD_WAKE_ALLOW, 8'h00, 1'b0);
		chk("ctrl", 16'h0080, u_uis_dev_model.regs[0]);
		conclude();
	end
endmodule : usb_device_iso_stall_suspend_tb_top
`default_nettype wire
